// [design/acs_bus_sequencer.sv]
`timescale 1ns/1ps

// Notes on behaviour
// R1: S0 drives function codes, read_write high.
// R2: Address bus driven on entering S1.
// R3: S2 asserts address and data strobes.
// R4: No termination by S4 end: wait states.
// R5: Legacy valid in S4 makes legacy cycle.
// R6: Fault and legacy sampled each falling edge; the code samples only on those ending S4, S6 and S8.
// R7: Slave drives read data during S6.
// R8: Entering S7 latch data, drop strobes.
// R9: Ending S7 float buses, read_write high.
// R10: Far side drops acknowledge after strobes drop.
// R11: Fault without acknowledge ends in S9.
// R12: Word both strobes; byte by select bit.
// R13: Acknowledge puts level on address, rest high.
// R14: Interrupter supplies vector with acknowledge.
// R15: Autovector is hex 18 plus level.
// R16: Far side never acknowledges and legacy together.
// R17: Vector read uses both strobes, low byte.
// R18: Halted: buses floated, arbitration still served.
// R19: Fault while halt asserted means retry.
// R20: Single step: one cycle per halt release.
// R21: Fault during fault processing halts for good.
// R22: Faults during retry are never double faults.
// R23: Bus state is half a processor clock.
module acs_bus_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // Core request side
  input  wire logic                     i_req_valid,
  input  wire acs_req_t                 i_req,
  output logic                          o_req_ready,
  output logic                          o_resp_valid,
  output acs_resp_t                     o_resp,
  input  wire logic                     i_instr_start,
  output logic                          o_halted,
  // Bus timing and control outputs
  output logic                          o_cpu_clk,
  output logic [`ACS_FC_W-1:0]          o_function_code_outputs,
  output logic [`ACS_ADDR_W-1:1]        o_addr,
  output logic                          o_addr_oe_n,
  output logic [`ACS_DATA_W-1:0]        o_data,
  output logic                          o_data_oe_n,
  output logic                          o_read_write_select,
  output logic                          o_address_strobe_n,
  output logic                          o_upper_byte_strobe_n,
  output logic                          o_lower_byte_strobe_n,
  output logic                          o_single_data_strobe_n,
  // Bus inputs from memory and glue logic
  input  wire logic [`ACS_DATA_W-1:0]   i_data,
  input  wire logic                     i_transfer_acknowledge_n,
  input  wire logic                     i_bus_fault_input_n,
  input  wire logic                     i_legacy_peripheral_valid_n,
  input  wire logic                     i_autovector_request_n,
  // Open-drain halt line
  input  wire logic                     i_halt_line_n,
  output logic                          o_halt_line_n,
  output logic                          o_halt_line_oe_n,
  // Bus arbitration
  input  wire logic                     i_bus_request_n,
  output logic                          o_bus_grant_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State and working registers

  acs_state_t                state_r;
  acs_state_t                state_nxt;
  acs_req_t                  cur_r;
  logic                      phase_r;
  logic                      retry_r;
  logic                      ack_r;
  logic                      fault_r;
  logic                      legacy_r;
  logic                      auto_r;
  logic                      halt_seen_r;
  logic                      exc_r;
  logic                      dbl_r;
  logic                      grant_r;
  logic [`ACS_DATA_W-1:0]    rdata_r;
  logic                      fault_only;
  logic                      cycle_end;
  logic                      take_retry;
  logic                      report_fault;
  logic                      double_fault;
  logic                      start_ok;
  logic                      term_now;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address lines are driven from S1 until the cycle ends
  function automatic logic addr_phase(input acs_state_t s);
    addr_phase = (s == ST_S1) || (s == ST_S2) || (s == ST_S3) || (s == ST_S4) ||
                 (s == ST_WAIT) || (s == ST_S5) || (s == ST_S6) || (s == ST_S7) ||
                 (s == ST_S8) || (s == ST_S9);
  endfunction

  // Strobes span S2 up to the falling edge entering S7
  function automatic logic strobe_phase(input acs_state_t s);
    strobe_phase = (s == ST_S2) || (s == ST_S3) || (s == ST_S4) || (s == ST_WAIT) ||
                   (s == ST_S5) || (s == ST_S6);
  endfunction

  // Upper strobe wanted: words, vector reads, or even bytes
  function automatic logic want_upper(input acs_req_t r);
    want_upper = r.word || r.iack || !r.addr[0]; // R12 R17
  endfunction

  // Lower strobe wanted: words, vector reads, or odd bytes
  function automatic logic want_lower(input acs_req_t r);
    want_lower = r.word || r.iack || r.addr[0]; // R12 R17
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decisions

  // A cycle may begin only on a rising processor clock edge
  assign start_ok     = !phase_r && !grant_r && i_halt_line_n && !dbl_r; // R20 R23
  // Termination seen on this falling edge; autovector only counts on acknowledge cycles
  assign term_now     = !i_transfer_acknowledge_n || !i_bus_fault_input_n || !i_legacy_peripheral_valid_n ||
                        (cur_r.iack && !i_autovector_request_n);
  assign fault_only   = fault_r && !ack_r;
  assign cycle_end    = (state_r == ST_S9) || ((state_r == ST_S7) && !fault_only);
  // Halt asserted with the fault turns it into a retry
  assign take_retry   = cycle_end && fault_only && halt_seen_r; // R19
  assign report_fault = cycle_end && fault_only && !halt_seen_r;
  // Retried cycles never count as double faults
  assign double_fault = report_fault && exc_r && !retry_r; // R21 R22

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!i_halt_line_n && phase_r) begin
          state_nxt = ST_HALT;
        end else if (i_req_valid && start_ok) begin
          state_nxt = ST_S0;
        end
      end
      ST_S0:   state_nxt = ST_S1;
      ST_S1:   state_nxt = ST_S2;
      ST_S2:   state_nxt = ST_S3;
      ST_S3:   state_nxt = ST_S4;
      ST_S4: begin
        // Whole-clock wait pairs until something terminates the cycle
        state_nxt = term_now ? ST_S5 : ST_WAIT; // R4 R5
      end
      ST_WAIT: state_nxt = ST_S4; // R4
      ST_S5:   state_nxt = ST_S6;
      ST_S6:   state_nxt = ST_S7;
      ST_S7: begin
        if (fault_only) begin
          state_nxt = ST_S8; // R11
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_S8:   state_nxt = ST_S9;
      ST_S9: begin
        if (double_fault) begin
          state_nxt = ST_HALT; // R21
        end else if (take_retry) begin
          state_nxt = ST_RETRY;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_RETRY: begin
        // Rerun once halt is released, on a rising processor edge
        if (i_halt_line_n && !phase_r && !grant_r) begin
          state_nxt = ST_S0; // R19
        end
      end
      ST_HALT: begin
        // Single step: halt released lets exactly one cycle out
        if (!dbl_r && i_halt_line_n) begin
          state_nxt = ST_IDLE; // R20
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Processor clock: high in even states, low in odd ones
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_r   <= 1'b0;
      o_cpu_clk <= 1'b0;
    end else begin
      phase_r   <= !phase_r; // R23
      o_cpu_clk <= !phase_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request capture and retry bookkeeping

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_r       <= '0;
      retry_r     <= 1'b0;
      o_req_ready <= 1'b0;
    end else begin
      o_req_ready <= (state_r == ST_IDLE) && (state_nxt == ST_S0);
      if ((state_r == ST_IDLE) && (state_nxt == ST_S0)) begin
        cur_r   <= i_req;
        retry_r <= 1'b0;
      end else if (state_nxt == ST_RETRY) begin
        retry_r <= 1'b1; // R22
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Falling-edge sampling from S4 onward; flags cleared at S0

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r       <= 1'b0;
      fault_r     <= 1'b0;
      legacy_r    <= 1'b0;
      auto_r      <= 1'b0;
      halt_seen_r <= 1'b0;
    end else if (state_nxt == ST_S0) begin
      ack_r       <= 1'b0;
      fault_r     <= 1'b0;
      legacy_r    <= 1'b0;
      auto_r      <= 1'b0;
      halt_seen_r <= 1'b0;
    end else if ((state_r == ST_S4) || (state_r == ST_S6) || (state_r == ST_S8)) begin
      ack_r       <= ack_r || !i_transfer_acknowledge_n;
      fault_r     <= fault_r || !i_bus_fault_input_n; // R6
      legacy_r    <= legacy_r || !i_legacy_peripheral_valid_n; // R5 R6
      auto_r      <= auto_r || (cur_r.iack && !i_autovector_request_n);
      halt_seen_r <= halt_seen_r || (!i_bus_fault_input_n && !i_halt_line_n);
    end
  end

  // Read data latched on the falling edge entering S7
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= '0;
    end else if ((state_r == ST_S6) && !cur_r.write) begin
      rdata_r <= i_data; // R7 R8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault processing window and double-fault lock

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      exc_r <= 1'b0;
      dbl_r <= 1'b0;
    end else begin
      // A new fault beats an instruction start in the same cycle
      if (report_fault) begin
        exc_r <= 1'b1;
      end else if (i_instr_start) begin
        exc_r <= 1'b0;
      end
      // Only reset leaves this lock
      if (double_fault) begin
        dbl_r <= 1'b1; // R21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion toward the core

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_resp_valid <= 1'b0;
      o_resp       <= '0;
    end else begin
      o_resp_valid <= cycle_end && !take_retry;
      if (cycle_end && !take_retry) begin
        o_resp.rdata   <= rdata_r;
        o_resp.fault   <= fault_only;
        o_resp.autovec <= cur_r.iack && (auto_r || legacy_r);
        o_resp.legacy  <= legacy_r && !cur_r.iack; // R5
        if (cur_r.iack && (auto_r || legacy_r)) begin
          o_resp.vector <= `ACS_AUTOVEC_BASE + {5'h0, cur_r.level}; // R15
        end else begin
          // Upper data lines carry nothing useful on a vector read
          o_resp.vector <= rdata_r[`ACS_VEC_W-1:0]; // R14 R17
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins, all registered; cycle pins from the next state, arbitration from the current one

  // Function codes and direction
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_function_code_outputs <= '0;
      o_read_write_select     <= 1'b1;
    end else begin
      if (state_nxt == ST_S0) begin
        o_function_code_outputs <= (state_r == ST_RETRY) ? cur_r.fc : i_req.fc; // R1
      end
      // High for reads and outside cycles; low for writes from S2
      o_read_write_select <= !((state_nxt == ST_S0) ? 1'b0 :
                              (addr_phase(state_nxt) && (state_nxt != ST_S1) && cur_r.write)); // R1 R9
    end
  end

  // Address bus; floats outside the cycle and while halted
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_addr      <= '0;
      o_addr_oe_n <= 1'b1;
    end else begin
      o_addr_oe_n <= !addr_phase(state_nxt); // R2 R9 R18
      if ((state_nxt == ST_S1) && cur_r.iack) begin
        o_addr <= '1;
        o_addr[`ACS_LEVEL_LSB+`ACS_LEVEL_W-1:`ACS_LEVEL_LSB] <= cur_r.level; // R13
      end else if (state_nxt == ST_S1) begin
        o_addr <= cur_r.addr[`ACS_ADDR_W-1:1]; // R2
      end
    end
  end

  // Write data from S3 to the cycle end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data      <= '0;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data_oe_n <= !(cur_r.write && addr_phase(state_nxt) &&
                       (state_nxt != ST_S1) && (state_nxt != ST_S2)); // R9 R18
      if (state_nxt == ST_S3) begin
        o_data <= cur_r.wdata;
      end
    end
  end

  // Strobes: on at S2, off on the falling edge entering S7
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_address_strobe_n     <= 1'b1;
      o_upper_byte_strobe_n  <= 1'b1;
      o_lower_byte_strobe_n  <= 1'b1;
      o_single_data_strobe_n <= 1'b1;
    end else begin
      o_address_strobe_n     <= !strobe_phase(state_nxt); // R3 R8
      o_upper_byte_strobe_n  <= !(strobe_phase(state_nxt) && want_upper(cur_r)); // R3 R8 R12
      o_lower_byte_strobe_n  <= !(strobe_phase(state_nxt) && want_lower(cur_r)); // R3 R8 R12
      o_single_data_strobe_n <= !strobe_phase(state_nxt); // R3
    end
  end

  // Halt line pulled low only after a double fault; arbitration served when idle or halted
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_halt_line_n    <= 1'b1;
      o_halt_line_oe_n <= 1'b1;
      o_halted         <= 1'b0;
      grant_r          <= 1'b0;
      o_bus_grant_n    <= 1'b1;
    end else begin
      o_halt_line_n    <= !(dbl_r || double_fault);
      o_halt_line_oe_n <= !(dbl_r || double_fault); // R21
      o_halted         <= (state_nxt == ST_HALT);
      if (i_bus_request_n) begin
        grant_r <= 1'b0;
      end else if ((state_r == ST_IDLE) || (state_r == ST_HALT) || (state_r == ST_RETRY)) begin
        grant_r <= 1'b1; // R18
      end
      o_bus_grant_n <= !(!i_bus_request_n &&
                         (grant_r || (state_r == ST_IDLE) || (state_r == ST_HALT) || (state_r == ST_RETRY)));
    end
  end

endmodule

// [design/acs_params.svh]
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Bus geometry
`define ACS_ADDR_W       24
`define ACS_DATA_W       16
`define ACS_FC_W         3
`define ACS_LEVEL_W      3
`define ACS_VEC_W        8

// Autovector base added to the acknowledged level
`define ACS_AUTOVEC_BASE 8'h18

// Acknowledge level sits on address bits 3..1
`define ACS_LEVEL_LSB    1

`endif

// [design/acs_pkg.sv]
package acs_pkg;
  `include "acs_params.svh"

  // Bus sequencer states; S0 to S9 and WAIT each last half a processor clock
  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_WAIT, ST_S5,
    ST_S6, ST_S7, ST_S8, ST_S9, ST_RETRY, ST_HALT
  } acs_state_t;

  // Core request for one bus cycle
  typedef struct packed {
    logic [`ACS_FC_W-1:0]    fc;
    logic [`ACS_ADDR_W-1:0]  addr;
    logic                    write;
    logic                    word;
    logic                    iack;
    logic [`ACS_LEVEL_W-1:0] level;
    logic [`ACS_DATA_W-1:0]  wdata;
  } acs_req_t;

  // Completion of one bus cycle
  typedef struct packed {
    logic [`ACS_DATA_W-1:0] rdata;
    logic [`ACS_VEC_W-1:0]  vector;
    logic                   fault;
    logic                   autovec;
    logic                   legacy;
  } acs_resp_t;
endpackage

// [tb/acs_bus_chk.sv]
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_bus_chk
  import acs_pkg::*;
(
  // Clock, reset and request side
  input wire logic                 i_clk, i_rst, o_req_ready, o_resp_valid, o_halted,
  input wire acs_req_t             i_req,
  input wire acs_resp_t            o_resp,
  // Bus pins
  input wire logic [`ACS_FC_W-1:0] o_function_code_outputs,
  input wire logic [`ACS_ADDR_W-1:1] o_addr,
  input wire logic [`ACS_DATA_W-1:0] o_data,
  input wire logic                 o_addr_oe_n, o_data_oe_n, o_read_write_select, o_address_strobe_n,
  input wire logic                 o_upper_byte_strobe_n, o_lower_byte_strobe_n, o_single_data_strobe_n,
  input wire logic                 i_transfer_acknowledge_n, i_bus_fault_input_n,
  input wire logic                 i_legacy_peripheral_valid_n, i_autovector_request_n, o_halt_line_oe_n, o_cpu_clk
);
  logic [22:0] iack_addr;
  logic        idle_in;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Expected acknowledge address and an all-quiet terminator view
  assign iack_addr = {20'hF_FFFF, i_req.level};
  assign idle_in   = i_transfer_acknowledge_n && i_bus_fault_input_n &&
                     i_legacy_peripheral_valid_n && i_autovector_request_n;
  ////////////////////////////////
  chk_start_fc_rw: assert property (o_req_ready |->
    o_function_code_outputs == i_req.fc && o_read_write_select) else $error("start codes wrong");
  // Ready stands during S0, so the address shows one cycle on and the strobes one more
  chk_addr_then_strobe: assert property (o_req_ready |-> ##1 (!o_addr_oe_n && o_address_strobe_n)
    ##1 !o_address_strobe_n && !o_single_data_strobe_n) else $error("address or strobe order wrong");
  chk_addr_value: assert property (o_req_ready |=>
    o_addr == (i_req.iack ? iack_addr : i_req.addr[23:1])) else $error("address value wrong");
  chk_byte_lanes: assert property (o_req_ready && (i_req.write || i_req.iack) |-> ##2
    o_upper_byte_strobe_n == (!i_req.word && !i_req.iack && i_req.addr[0]) &&
    o_lower_byte_strobe_n == (!i_req.word && !i_req.iack && !i_req.addr[0])) else $error("byte lanes wrong");
  chk_strobe_span: assert property ($fell(o_address_strobe_n) |->
    (!o_address_strobe_n) [*5]) else $error("strobe too short");
  chk_wait_insert: assert property ($fell(o_address_strobe_n) ##2 idle_in |->
    ##1 (!o_address_strobe_n) [*4]) else $error("no wait state inserted");
  chk_ack_finish: assert property ($fell(o_address_strobe_n) ##2 !i_transfer_acknowledge_n |->
    ##3 o_address_strobe_n) else $error("acknowledged cycle late");
  chk_strobes_drop: assert property ($rose(o_address_strobe_n) |->
    o_upper_byte_strobe_n && o_lower_byte_strobe_n && o_single_data_strobe_n) else $error("strobes split");
  chk_bus_float: assert property (o_resp_valid && !o_resp.fault |-> o_addr_oe_n && o_data_oe_n &&
    o_read_write_select && $past(o_address_strobe_n) && !$past(o_address_strobe_n, 2)) else $error("float late");
  chk_fault_late: assert property (o_resp_valid && o_resp.fault |->
    $past(o_address_strobe_n, 3) && !$past(o_address_strobe_n, 4)) else $error("fault end not S9");
  chk_halt_float: assert property (o_halted |->
    o_addr_oe_n && o_data_oe_n && !o_req_ready) else $error("bus driven while halted");
  chk_double_stick: assert property (!o_halt_line_oe_n |=>
    !o_halt_line_oe_n && o_halted) else $error("double fault halt left");
  // Write data on the bus from S3 onward
  chk_write_data: assert property (o_req_ready && i_req.write |-> ##3
    !o_data_oe_n && o_data == i_req.wdata) else $error("write data wrong");
  // Processor clock halves the fast clock and is high in S0
  chk_cpu_clk: assert property (!$past(i_rst) |-> o_cpu_clk != $past(o_cpu_clk) &&
    (o_cpu_clk || !o_req_ready)) else $error("processor clock wrong");
  // Main scenarios reached
  cover property (o_resp_valid && o_resp.fault);
  cover property (o_resp_valid && o_resp.autovec);
  cover property ($rose(o_halted));
endmodule
bind acs_bus_sequencer acs_bus_chk i_acs_bus_chk (.i_clk, .i_rst, .o_req_ready, .o_resp_valid, .o_halted,
  .i_req, .o_resp, .o_function_code_outputs, .o_addr, .o_addr_oe_n, .o_data_oe_n, .o_read_write_select,
  .o_address_strobe_n, .o_upper_byte_strobe_n, .o_lower_byte_strobe_n, .o_single_data_strobe_n,
  .i_transfer_acknowledge_n, .i_bus_fault_input_n, .i_legacy_peripheral_valid_n, .i_autovector_request_n,
  .o_halt_line_oe_n, .o_cpu_clk, .o_data);

// [tb/acs_bus_partner.sv]
`timescale 1ns/1ps
`include "acs_params.svh"
// Memory, peripheral and glue logic seen from the sequencer pins
module acs_bus_partner (
  // Clock, reset and strobes from the sequencer
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_as_n,
  input  wire logic        i_rw,
  // Scenario controls: answer kind, delay, read data
  input  wire logic [1:0]  i_kind,
  input  wire logic [3:0]  i_wait,
  input  wire logic [15:0] i_rdata,
  // Answers back to the sequencer
  output logic [15:0]      o_data,
  output logic             o_ack_n,
  output logic             o_flt_n,
  output logic             o_leg_n,
  output logic             o_autovector_request_n
);
  logic [3:0]  cnt_r;
  logic [15:0] last_r;
  logic        go;
  ////////////////////////////////
  // Cycles since strobe fell; saturates so long stalls stay stalled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= 4'h0;
      last_r <= 16'h0000;
    end else begin
      cnt_r  <= i_as_n ? 4'h0 : (cnt_r == 4'hF ? cnt_r : cnt_r + 4'h1);
      last_r <= o_data;
    end
  end
  // One answer at a time, withdrawn as soon as strobes go high
  assign go       = !i_as_n && (cnt_r >= i_wait);
  assign o_ack_n  = !(go && i_kind == 2'd0);
  assign o_flt_n  = !(go && i_kind == 2'd1);
  assign o_leg_n  = !(go && i_kind == 2'd2);
  assign o_autovector_request_n = !(go && i_kind == 2'd3);
  // Released data bus toggles so a stale value never looks valid
  assign o_data = (!i_as_n && i_rw) ? i_rdata : ~last_r;
endmodule

// [tb/acs_bus_sequencer_test.sv]
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_bus_sequencer_test;
  import acs_pkg::*;
  logic        i_clk, i_rst, i_req_valid, i_instr_start, i_bus_request_n, halt_tb_n, halt_w;
  acs_req_t    i_req, r;
  acs_resp_t   o_resp;
  logic [1:0]  kind;
  logic [3:0]  wt;
  logic [15:0] rdata, p_data, o_data;
  logic        ack_n, flt_n, leg_n, autovector_request_n, o_req_ready, o_resp_valid, o_halted, o_cpu_clk;
  logic        o_addr_oe_n, o_data_oe_n, o_read_write_select, o_address_strobe_n, o_upper_byte_strobe_n;
  logic        o_lower_byte_strobe_n, o_single_data_strobe_n, o_halt_line_n, o_halt_line_oe_n, o_bus_grant_n;
  logic [2:0]  o_function_code_outputs;
  logic [23:1] o_addr;
  logic [63:0] rnd;
  integer      seed, num_errors, check_count, i, j;
  // Open-drain halt line with pull-up
  assign halt_w = halt_tb_n & (o_halt_line_oe_n | o_halt_line_n);
  acs_bus_sequencer i_acs_bus_sequencer (.i_clk, .i_rst, .i_req_valid, .i_req, .o_req_ready, .o_resp_valid,
    .o_resp, .i_instr_start, .o_halted, .o_cpu_clk, .o_function_code_outputs, .o_addr, .o_addr_oe_n, .o_data,
    .o_data_oe_n, .o_read_write_select, .o_address_strobe_n, .o_upper_byte_strobe_n, .o_lower_byte_strobe_n,
    .o_single_data_strobe_n, .i_data(p_data), .i_transfer_acknowledge_n(ack_n), .i_bus_fault_input_n(flt_n),
    .i_legacy_peripheral_valid_n(leg_n), .i_autovector_request_n(autovector_request_n), .i_halt_line_n(halt_w),
    .o_halt_line_n, .o_halt_line_oe_n, .i_bus_request_n, .o_bus_grant_n);
  acs_bus_partner i_acs_bus_partner (.i_clk, .i_rst, .i_as_n(o_address_strobe_n), .i_rw(o_read_write_select),
    .i_kind(kind), .i_wait(wt), .i_rdata(rdata), .o_data(p_data), .o_ack_n(ack_n), .o_flt_n(flt_n),
    .o_leg_n(leg_n), .o_autovector_request_n(autovector_request_n));
  ////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic waitsig(ref logic s, input logic v);
    int n;
    for (n = 0; n < 300 && s !== v; n++) tick(1);
    if (n == 300) begin
      num_errors++;
      summarize;
    end
  endtask
  // Cycles from ready to completion: two per wait, two more for a fault
  function automatic int exp_len(input logic [1:0] k, input logic [3:0] w);
    return 8 + 2 * ((w > 4'd2) ? (w - 4'd1) / 2 : 0) + ((k == 2'd1) ? 2 : 0);
  endfunction
  // One bus cycle; answer kind and delay are set by the caller
  task automatic cyc(input acs_req_t q, input bit tlen);
    int n;
    logic [15:0] d;
    d = $random(seed);
    i_req = q;
    rdata = d;
    i_req_valid = 1'b1;
    waitsig(o_req_ready, 1'b1);
    i_req_valid = 1'b0;
    for (n = 0; n < 300 && o_resp_valid !== 1'b1; n++) tick(1);
    if (n == 300) begin
      num_errors++;
      summarize;
    end
    if (tlen) check(n, exp_len(kind, wt));
    check(o_resp.fault, kind == 2'd1);
    if (kind != 2'd1 && !q.write && !q.iack) check(o_resp.rdata, d);
    if (q.iack && kind == 2'd0) check(o_resp.vector, d[7:0]);
    if (q.iack && kind > 2'd1) check(o_resp.vector, `ACS_AUTOVEC_BASE + q.level);
    if (q.iack && kind > 2'd1) check(o_resp.autovec, 1'b1);
    if (!q.iack && kind == 2'd2) check(o_resp.legacy, 1'b1);
  endtask
  ////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // Main sequence
  initial begin
    seed = 32'h8072;
    num_errors = 0;
    check_count = 0;
    i_rst = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_instr_start = 1'b0;
    i_bus_request_n = 1'b1;
    halt_tb_n = 1'b1;
    kind = 2'd0;
    wt = 4'h0;
    rdata = 16'h0000;
    tick(5);
    i_rst = 1'b0;
    tick(2);
    // Random cycles; byte writes on both lanes and every acknowledge kind first
    for (i = 0; i < 40; i++) begin
      rnd = {$random(seed), $random(seed)};
      r = rnd[48:0];
      r.iack = (i % 5) == 0;
      if (r.iack) r.write = 1'b0;
      if (i < 2) begin
        r.write = 1'b1;
        r.word = 1'b0;
        r.iack = 1'b0;
        r.addr[0] = i[0];
      end
      kind = r.iack ? (((i / 5) % 3 == 0) ? 2'd0 : 2'((i / 5) % 3 + 1)) : {rnd[60], 1'b0};
      wt = {1'b0, rnd[63:61]};
      cyc(r, 1'b1);
    end
    // Faults under halt are retried twice, then the cycle completes and halts
    r = '0;
    r.addr = 24'h00_2468;
    kind = 2'd1;
    wt = 4'h0;
    fork
      cyc(r, 1'b0);
      for (j = 0; j < 3; j++) begin
        waitsig(o_address_strobe_n, 1'b0);
        halt_tb_n = 1'b0;
        waitsig(o_address_strobe_n, 1'b1);
        if (j > 0) kind = 2'd0;
        tick(3);
        if (j == 2) check(o_halted, 1'b1);
        halt_tb_n = 1'b1;
      end
    join
    tick(3);
    check(o_halted, 1'b0);
    check(o_halt_line_oe_n, 1'b1);
    // Fault, new instruction, fault, then a second fault halts for good
    r.addr = 24'h00_1000;
    kind = 2'd1;
    cyc(r, 1'b1);
    i_instr_start = 1'b1;
    tick(1);
    i_instr_start = 1'b0;
    cyc(r, 1'b1);
    check(o_halted, 1'b0);
    i_req_valid = 1'b1;
    waitsig(o_req_ready, 1'b1);
    i_req_valid = 1'b0;
    tick(20);
    check(o_halted, 1'b1);
    check(o_halt_line_oe_n, 1'b0);
    // Arbitration still served while halted
    i_req_valid = 1'b1;
    i_bus_request_n = 1'b0;
    waitsig(o_bus_grant_n, 1'b0);
    check(o_addr_oe_n, 1'b1);
    i_req_valid = 1'b0;
    i_bus_request_n = 1'b1;
    // Only reset clears the double fault halt
    i_rst = 1'b1;
    tick(2);
    i_rst = 1'b0;
    tick(2);
    check(o_halted, 1'b0);
    check(o_halt_line_oe_n, 1'b1);
    summarize;
  end
endmodule
